// File: src/mmc_defines.svh
/*
  Constants of the module management control block: pin indices, reset
  values, timing figures and the cycle counts derived from them.
  Assumes a 20 MHz system clock.
*/
`ifndef MMC_DEFINES_SVH
`define MMC_DEFINES_SVH

// ****************************************
// Clock
// ****************************************
`define MMC_CLK_HZ 20000000

// ****************************************
// Timing figures and cycle counts
// ****************************************
`define MMC_T_INIT_MS 2000
`define MMC_T_INIT_CYC ((`MMC_T_INIT_MS) * ((`MMC_CLK_HZ) / 1000))
`define MMC_T_RSTMIN_US 2
`define MMC_T_RSTMIN_CYC (((`MMC_T_RSTMIN_US) * (`MMC_CLK_HZ) + 999999) / 1000000)

// ****************************************
// Synchronised pin positions and reset values
// ****************************************
`define MMC_PIN_RST_N 0
`define MMC_PIN_LP 1
`define MMC_PIN_SEL_N 2
`define MMC_PIN_RESET_VAL 3'h5

// ****************************************
// Flag vector layout
// ****************************************
`define MMC_NFLAG 16
`define MMC_LOS_LO 0
`define MMC_FAULT_LO 4
`define MMC_LOL_LO 8

`endif

// File: src/mmc_pkg.sv
/*
  Types of the module management control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mmc_pkg;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    MMC_CLR_READY = 2'b00,
    MMC_CLR_LOS = 2'b01,
    MMC_CLR_FAULT = 2'b10,
    MMC_CLR_LOL = 2'b11
  } mmc_clr_grp_t;

  typedef enum logic [1:0] {
    MMC_ST_INIT = 2'b00,
    MMC_ST_HOLD = 2'b01,
    MMC_ST_RUN = 2'b10
  } mmc_st_t;

endpackage

// File: src/mmc_top.sv
/*
  Management control and status logic of a pluggable transceiver module,
  module side: pin filtering, reset and initialisation, latched flags,
  masks, interrupt line, power and select handling.
  Assumes a two-wire serial slave elsewhere that gives one-cycle strobes
  on the falling serial clock edge after the stop bit of each transaction.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mmc_defines.svh"

module mmc_top #(
  parameter int unsigned INIT_CYCLES = `MMC_T_INIT_CYC,
  parameter int unsigned RESET_MIN_CYCLES = `MMC_T_RSTMIN_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic module_reset_n,
  input wire logic low_power_request,
  input wire logic module_select_n,
  input wire logic [3:0] rx_los_cond,
  input wire logic [3:0] tx_fault_cond,
  input wire logic [3:0] tx_lock_loss_cond,
  input wire logic [3:0] rx_lock_loss_cond,
  input wire logic read_clear,
  input wire mmc_pkg::mmc_clr_grp_t read_clear_grp,
  input wire logic mask_write,
  input wire logic [15:0] mask_wdata,
  input wire logic power_down_write,
  input wire logic power_down_wdata,
  output logic interrupt_out_n,
  output logic data_not_ready,
  output logic init_done_flag,
  output logic [3:0] rx_los_flags,
  output logic [3:0] tx_fault_flags,
  output logic [7:0] lock_loss_flags,
  output logic [15:0] flag_mask,
  output logic power_down,
  output logic low_power_state,
  output logic serial_respond_en
);
  import mmc_pkg::*;

  // ****************************************
  // Parameter checks
  // ****************************************
  if (INIT_CYCLES < 2) begin : g_bad_init
    $error("INIT_CYCLES must be at least 2");
  end
  if (RESET_MIN_CYCLES < 1 || RESET_MIN_CYCLES > 16'hfffe) begin : g_bad_rst
    $error("RESET_MIN_CYCLES out of range");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam logic [2:0] PIN_RST = `MMC_PIN_RESET_VAL;
  logic [2:0] pin_raw;
  logic [2:0] pin_s1, pin_s2, pin_s3;
  logic [2:0] pin_f;

  assign pin_raw = {module_select_n, low_power_request, module_reset_n};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_s1 <= `MMC_PIN_RESET_VAL;
      pin_s2 <= `MMC_PIN_RESET_VAL;
      pin_s3 <= `MMC_PIN_RESET_VAL;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // A change is accepted only once two stages agree, which rejects a
  // single-cycle glitch at the cost of one cycle of latency.
  for (genvar p = 0; p < 3; p++) begin : g_pin
    always_ff @(posedge clk) begin
      if (!resetn) begin
        pin_f[p] <= PIN_RST[p];
      end else if (pin_s2[p] == pin_s3[p]) begin
        pin_f[p] <= pin_s3[p];
      end
    end
  end

  // ****************************************
  // Reset pulse filter
  // ****************************************
  logic [15:0] rst_low_cnt;
  logic hold_rst;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rst_low_cnt <= 16'h0;
      hold_rst <= 1'b0;
    end else if (pin_f[`MMC_PIN_RST_N]) begin
      rst_low_cnt <= 16'h0;
      hold_rst <= 1'b0;
    end else begin
      if (rst_low_cnt != RESET_MIN_CYCLES[15:0]) begin
        rst_low_cnt <= rst_low_cnt + 16'h1;
      end
      if (rst_low_cnt == RESET_MIN_CYCLES[15:0]) begin
        hold_rst <= 1'b1;
      end
    end
  end

  // ****************************************
  // Initialisation sequence
  // ****************************************
  mmc_st_t st;
  logic [31:0] init_cnt;
  logic init_last;

  assign init_last = (st == MMC_ST_INIT) && (init_cnt == INIT_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= MMC_ST_INIT;
      init_cnt <= 32'h0;
    end else if (hold_rst) begin
      st <= MMC_ST_HOLD;
      init_cnt <= 32'h0;
    end else begin
      unique case (st)
        MMC_ST_HOLD: st <= MMC_ST_INIT;
        MMC_ST_INIT: begin
          if (init_last) begin
            st <= MMC_ST_RUN;
          end else begin
            init_cnt <= init_cnt + 32'h1;
          end
        end
        MMC_ST_RUN: st <= MMC_ST_RUN;
        default: st <= MMC_ST_INIT;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      data_not_ready <= 1'b1;
    end else begin
      data_not_ready <= hold_rst || ((st != MMC_ST_RUN) && !init_last);
    end
  end

  // Ready event is a flag like the others: set wins over a same-cycle read
  always_ff @(posedge clk) begin
    if (!resetn) begin
      init_done_flag <= 1'b0;
    end else if (hold_rst || (st != MMC_ST_RUN && !init_last)) begin
      init_done_flag <= 1'b0;
    end else if (init_last) begin
      init_done_flag <= 1'b1;
    end else if (read_clear && read_clear_grp == MMC_CLR_READY) begin
      init_done_flag <= 1'b0;
    end
  end

  // ****************************************
  // Latched flags
  // ****************************************
  logic [15:0] cond, cond_d, flag;

  assign cond = {tx_lock_loss_cond, rx_lock_loss_cond, tx_fault_cond, rx_los_cond};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cond_d <= 16'h0;
    end else begin
      cond_d <= cond;
    end
  end

  // Flags latch on the onset of a condition, so a lasting fault raises the
  // line once and a read really clears it.
  for (genvar i = 0; i < `MMC_NFLAG; i++) begin : g_flag
    localparam mmc_clr_grp_t GRP = (i < `MMC_FAULT_LO) ? MMC_CLR_LOS :
                                   (i < `MMC_LOL_LO) ? MMC_CLR_FAULT : MMC_CLR_LOL;
    always_ff @(posedge clk) begin
      if (!resetn) begin
        flag[i] <= 1'b0;
      end else if (st != MMC_ST_RUN) begin
        flag[i] <= 1'b0;
      end else if (cond[i] && !cond_d[i]) begin
        flag[i] <= 1'b1;
      end else if (read_clear && read_clear_grp == GRP) begin
        flag[i] <= 1'b0;
      end
    end
  end

  assign rx_los_flags = flag[`MMC_FAULT_LO-1:`MMC_LOS_LO];
  assign tx_fault_flags = flag[`MMC_LOL_LO-1:`MMC_FAULT_LO];
  assign lock_loss_flags = flag[15:`MMC_LOL_LO];

  // ****************************************
  // Masks and power-down control
  // ****************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      flag_mask <= 16'h0;
    end else if (mask_write) begin
      flag_mask <= mask_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      power_down <= 1'b0;
    end else if (hold_rst) begin
      power_down <= 1'b0;
    end else if (power_down_write) begin
      power_down <= power_down_wdata;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic pending;

  assign pending = (|(flag & ~flag_mask)) | init_done_flag;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      interrupt_out_n <= 1'b1;
    end else begin
      interrupt_out_n <= !pending;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      low_power_state <= 1'b0;
    end else begin
      low_power_state <= pin_f[`MMC_PIN_LP] | power_down;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      serial_respond_en <= 1'b0;
    end else begin
      serial_respond_en <= !pin_f[`MMC_PIN_SEL_N] && st != MMC_ST_HOLD;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_los_onset;
    st == MMC_ST_RUN && rx_los_cond[0] && !cond_d[0] && !flag_mask[0];
  endsequence
  sequence s_los_raised;
    rx_los_flags[0] ##1 !interrupt_out_n;
  endsequence
  property p_los_irq;
    @(posedge clk) disable iff (!resetn)
      s_los_onset |=> s_los_raised;
  endproperty
  a_los_irq: assert property (p_los_irq) else $error("los flag or irq missing");
  property p_fault_irq;
    @(posedge clk) disable iff (!resetn)
      (st == MMC_ST_RUN && tx_fault_cond[3] && !cond_d[7] && !flag_mask[7])
      |=> tx_fault_flags[3] ##1 !interrupt_out_n;
  endproperty
  a_fault_irq: assert property (p_fault_irq) else $error("fault flag or irq missing");
  property p_lol_map;
    @(posedge clk) disable iff (!resetn)
      (st == MMC_ST_RUN && $rose(tx_lock_loss_cond[3])) |=> lock_loss_flags[7];
  endproperty
  a_lol_map: assert property (p_lol_map) else $error("tx ch4 lock loss not in bit 7");
  property p_irq_hold;
    @(posedge clk) disable iff (!resetn)
      (|(flag & ~flag_mask)) |=> !interrupt_out_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq released with flag pending");
  property p_irq_release;
    @(posedge clk) disable iff (!resetn)
      (flag & ~flag_mask) == 16'h0 && !init_done_flag |=> interrupt_out_n;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("irq not released");
  property p_rst_min;
    @(posedge clk) disable iff (!resetn)
      $rose(hold_rst) |-> $past(rst_low_cnt) == RESET_MIN_CYCLES[15:0];
  endproperty
  a_rst_min: assert property (p_rst_min) else $error("reset accepted too early");
  sequence s_ready_seen;
    !data_not_ready && init_done_flag ##1 !interrupt_out_n;
  endsequence
  property p_init_done;
    @(posedge clk) disable iff (!resetn)
      init_last && !hold_rst |=> s_ready_seen;
  endproperty
  a_init_done: assert property (p_init_done) else $error("ready not signalled");
  property p_low_power;
    @(posedge clk) disable iff (!resetn)
      $rose(low_power_request) ##1 low_power_request[*4] |=> low_power_state;
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power not entered");
  property p_select;
    @(posedge clk) disable iff (!resetn)
      $fell(module_select_n) && st == MMC_ST_RUN && !hold_rst ##1 (st == MMC_ST_RUN)[*4]
      |=> serial_respond_en;
  endproperty
  a_select: assert property (p_select) else $error("select not answered");
  property p_deselect;
    @(posedge clk) disable iff (!resetn)
      $rose(module_select_n) ##1 module_select_n[*4] |=> !serial_respond_en;
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect ignored");

endmodule

`default_nettype wire

// File: tb/mmc_host_model.sv
/*
  Host controller model: drives the management pins and the strobes that
  the two-wire slave gives after a stop bit.
  Assumes the bench clock; all changes land on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module mmc_host_model (
  input wire logic clk,
  output logic module_reset_n,
  output logic low_power_request,
  output logic module_select_n,
  output logic read_clear,
  output var mmc_pkg::mmc_clr_grp_t read_clear_grp,
  output logic mask_write,
  output logic [15:0] mask_wdata,
  output logic power_down_write,
  output logic power_down_wdata
);
  import mmc_pkg::*;

  // ****************************************
  // Idle levels and host operations
  // ****************************************
  initial begin
    module_reset_n = 1'b1;
    low_power_request = 1'b0;
    module_select_n = 1'b1;
    read_clear = 1'b0;
    read_clear_grp = MMC_CLR_READY;
    mask_write = 1'b0;
    mask_wdata = 16'h0000;
    power_down_write = 1'b0;
    power_down_wdata = 1'b0;
  end

  // Qualifiers flip once the strobe drops, so a stale value is never trusted
  task automatic clear_read(input mmc_clr_grp_t g);
    @(negedge clk);
    read_clear <= 1'b1;
    read_clear_grp <= g;
    @(negedge clk);
    read_clear <= 1'b0;
    read_clear_grp <= mmc_clr_grp_t'(~g);
  endtask

  task automatic write_mask(input logic [15:0] v);
    @(negedge clk);
    mask_write <= 1'b1;
    mask_wdata <= v;
    @(negedge clk);
    mask_write <= 1'b0;
    mask_wdata <= ~v;
  endtask

  task automatic write_pd(input logic v);
    @(negedge clk);
    power_down_write <= 1'b1;
    power_down_wdata <= v;
    @(negedge clk);
    power_down_write <= 1'b0;
    power_down_wdata <= ~v;
  endtask

  task automatic set_pins(input logic lp, input logic sel_n);
    @(negedge clk);
    low_power_request <= lp;
    module_select_n <= sel_n;
  endtask

  // Caller picks the width; a short one is only used to probe the filter
  task automatic pin_reset(input int n);
    @(negedge clk);
    module_reset_n <= 1'b0;
    repeat (n) @(negedge clk);
    module_reset_n <= 1'b1;
  endtask
endmodule

`default_nettype wire

// File: tb/module_mgmt_control_timing_tb_top.sv
/*
  Self-checking bench of the management control block with a host model.
  Assumes shortened init and reset-filter counts; flags come from random
  condition patterns seeded by a fixed xorshift state.
*/
`timescale 1ns/1ps
`default_nettype none

module module_mgmt_control_timing_tb_top;
  import mmc_pkg::*;

  // ****************************************
  // Signals and instances
  // ****************************************
  localparam int INIT = 20;
  localparam int RMIN = 4;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] rx_los_cond = 4'h0;
  logic [3:0] tx_fault_cond = 4'h0;
  logic [3:0] tx_lock_loss_cond = 4'h0;
  logic [3:0] rx_lock_loss_cond = 4'h0;
  logic module_reset_n, low_power_request, module_select_n, read_clear;
  mmc_clr_grp_t read_clear_grp;
  logic mask_write, power_down_write, power_down_wdata;
  logic [15:0] mask_wdata;
  logic interrupt_out_n, data_not_ready, init_done_flag, power_down;
  logic low_power_state, serial_respond_en;
  logic [3:0] rx_los_flags, tx_fault_flags;
  logic [7:0] lock_loss_flags;
  logic [15:0] flag_mask;
  int n_fail = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h366f9003;

  always #25 clk = ~clk;

  mmc_top #(.INIT_CYCLES(INIT), .RESET_MIN_CYCLES(RMIN)) i_dut (.clk, .resetn,
    .module_reset_n, .low_power_request, .module_select_n, .rx_los_cond,
    .tx_fault_cond, .tx_lock_loss_cond, .rx_lock_loss_cond, .read_clear,
    .read_clear_grp, .mask_write, .mask_wdata, .power_down_write, .power_down_wdata,
    .interrupt_out_n, .data_not_ready, .init_done_flag, .rx_los_flags,
    .tx_fault_flags, .lock_loss_flags, .flag_mask, .power_down, .low_power_state,
    .serial_respond_en);

  mmc_host_model i_host (.clk, .module_reset_n, .low_power_request,
    .module_select_n, .read_clear, .read_clear_grp, .mask_write, .mask_wdata,
    .power_down_write, .power_down_wdata);

  // ****************************************
  // Helpers
  // ****************************************
  // Never zero, so every flag step really has an onset to latch
  function automatic logic [3:0] rnd4();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return (seed[3:0] == 4'h0) ? 4'h9 : seed[3:0];
  endfunction

  function automatic logic [7:0] got(input int g);
    case (g)
      1: return {4'h0, rx_los_flags};
      2: return {4'h0, tx_fault_flags};
      default: return lock_loss_flags;
    endcase
  endfunction

  task automatic set_cond(input int g, input logic [7:0] v);
    @(negedge clk);
    case (g)
      1: rx_los_cond = v[3:0];
      2: tx_fault_cond = v[3:0];
      default: {tx_lock_loss_cond, rx_lock_loss_cond} = v;
    endcase
  endtask

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Bounded by the init count plus the pin filter lag
  task automatic wait_init();
    int k;
    k = 0;
    while (data_not_ready !== 1'b0 && k < INIT + 10) begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, errors %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    #2000000;
    n_fail++;
    final_report();
  end

  initial begin
    logic [7:0] v;
    logic [3:0] m;
    cyc(3);
    resetn <= 1'b1;
    wait_init();
    chk(data_not_ready === 1'b0, "data not ready stuck");
    cyc(3);
    chk(interrupt_out_n === 1'b0 && init_done_flag === 1'b1, "no ready interrupt");
    i_host.clear_read(MMC_CLR_READY);
    cyc(3);
    chk(interrupt_out_n === 1'b1 && init_done_flag === 1'b0, "interrupt held after clear");
    for (int g = 1; g < 4; g++) begin
      v = {rnd4(), rnd4()};
      if (g < 3) v[7:4] = 4'h0;
      // Corner: always raise the channel that each flag property watches
      v[(g == 1) ? 0 : (g == 2) ? 3 : 7] = 1'b1;
      set_cond(g, v);
      cyc(4);
      chk(got(g) === v, "flag pattern");
      chk(interrupt_out_n === 1'b0, "flag interrupt missing");
      set_cond(g, 8'h00);
      i_host.clear_read(mmc_clr_grp_t'(g[1:0] + 2'd1));
      cyc(3);
      chk(interrupt_out_n === 1'b0, "released with flag pending");
      i_host.clear_read(mmc_clr_grp_t'(g[1:0]));
      cyc(3);
      chk(got(g) === 8'h00 && interrupt_out_n === 1'b1, "flag not cleared");
    end
    m = rnd4();
    i_host.write_mask({12'h000, m});
    cyc(2);
    chk(flag_mask === {12'h000, m}, "mask not taken");
    set_cond(1, {4'h0, m});
    cyc(4);
    chk(rx_los_flags === m && interrupt_out_n === 1'b1, "masked source fires");
    i_host.write_mask(16'h0000);
    cyc(3);
    chk(interrupt_out_n === 1'b0, "unmasked source silent");
    set_cond(1, 8'h00);
    i_host.clear_read(MMC_CLR_LOS);
    i_host.write_pd(1'b1);
    cyc(3);
    chk(power_down === 1'b1 && low_power_state === 1'b1, "power down ignored");
    i_host.write_pd(1'b0);
    cyc(3);
    chk(low_power_state === 1'b0, "power down stuck");
    i_host.set_pins(1'b1, 1'b0);
    cyc(8);
    chk(low_power_state === 1'b1 && serial_respond_en === 1'b1, "pins ignored");
    i_host.set_pins(1'b0, 1'b1);
    cyc(8);
    chk(low_power_state === 1'b0 && serial_respond_en === 1'b0, "pins stuck");
    i_host.pin_reset(RMIN - 2);
    cyc(12);
    chk(data_not_ready === 1'b0, "short pulse reset module");
    i_host.pin_reset(RMIN + 10);
    chk(data_not_ready === 1'b1, "reset pin ignored");
    wait_init();
    chk(data_not_ready === 1'b0, "no re-init");
    cyc(3);
    chk(interrupt_out_n === 1'b0, "no ready interrupt after reset");
    final_report();
  end
endmodule

`default_nettype wire
